//--- include/acarm_pkg.sv
package acarm_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int LVL_W = 4;
  localparam int CFG_W = 22;
  localparam int IRQ_W = 5;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam logic [CFG_W-1:0] CFG_RESET = 22'h000000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // interrupt status bit positions
  localparam int IRQ_EXT_ARM = 0;
  localparam int IRQ_TRIG0 = 1;
  localparam int IRQ_TRIG1 = 2;
  localparam int IRQ_PORT_OUT = 3;
  localparam int IRQ_CFG_ERR = 4;

  // tag counting setting of a state machine
  typedef enum logic [1:0] {
    TAG_OFF = 2'h0,
    TAG_TIME = 2'h1,
    TAG_STATE = 2'h2
  } acarm_tag_type;

  // acquisition sequencing, one-hot
  typedef enum logic [2:0] {
    ACQ_IDLE = 3'h1,
    ACQ_RUN = 3'h2,
    ACQ_DONE = 3'h4
  } acarm_acq_type;

  // control register, bit 0 at the bottom
  typedef struct packed {
    logic [LVL_W-1:0] lvl1;
    logic [LVL_W-1:0] lvl0;
    logic [1:0] arm_from_other;
    logic [1:0] wait_arm;
    logic ored;
    logic out_src;
    logic out_en;
    logic m1_on;
    acarm_tag_type tag1;
    acarm_tag_type tag0;
    logic [1:0] timing;
  } acarm_cfg_type;

  // per machine outputs toward the acquisition engine
  typedef struct packed {
    logic trig_en;
    logic trig;
    logic arm_pulse;
    logic [LVL_W-1:0] arm_level;
    logic time_tag;
    logic state_cnt;
    logic timing;
  } acarm_mach_type;

endpackage : acarm_pkg

//--- src/acarm_core.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Functional notes
// - at most one machine in timing mode
// - tag setting off/time/state; time tags when selected
// - timing machine always stores time tags
// - correlate on time tags only, never state counts
// - port out rises when source machine triggers
// - source select picks which machine drives port out
// - combined trigger forces other, arm goes anyway
// - waiting machine ignores trigger until armed
// - arm goes to chosen level, default first
// - waiting source emits arm only after armed+trigger
module acarm_core (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [1:0] trig_hit_i,
  input wire logic [1:0] sample_i,
  input wire logic ext_trig_i,
  output acarm_pkg::acarm_mach_type [1:0] mach_o,
  output logic port_out_o,
  output logic irq_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    acarm_pkg::acarm_cfg_type cfg;
    acarm_pkg::acarm_acq_type acq;
    logic [acarm_pkg::IRQ_W-1:0] sts;
    logic [acarm_pkg::IRQ_W-1:0] mask;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [1:0] armed;
    logic [1:0] trigd;
    logic [1:0] arm_pulse;
    logic [1:0] trig_pulse;
    logic [1:0] time_tag;
    logic [1:0] state_cnt;
    logic port_out;
    logic [31:0] rdata;
  } acarm_st_type;

  acarm_st_type st;
  acarm_st_type next_st;
  logic ext_edge;
  logic running;
  logic corr_ok;
  logic [1:0] active;
  logic [1:0] arm_ev;
  logic [1:0] en;
  logic [1:0] own;
  logic [1:0] fire;
  logic [acarm_pkg::IRQ_W-1:0] ev;
  logic [acarm_pkg::IRQ_W-1:0] clr;
  acarm_pkg::acarm_cfg_type wcfg;

  // ****************************************
  // next state
  // ****************************************
  // one process builds every next value; the register below copies it
  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h00000000;
    wcfg = acarm_pkg::acarm_cfg_type'(wdata_i[acarm_pkg::CFG_W-1:0]);
    clr = '0;
    ev = '0;
    // the second and third stages feed the edge detector
    next_st.sync1 = ext_trig_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    ext_edge = st.sync2 & ~st.sync3;
    running = (st.acq == acarm_pkg::ACQ_RUN);
    active = {st.cfg.m1_on, 1'b1};
    // a machine that waits sees no trigger until armed
    en = ~st.cfg.wait_arm | st.armed;
    own = {2{running}} & active & ~st.trigd & trig_hit_i & en;
    // combined mode: the first hit forces the other machine
    fire = own;
    if (st.cfg.ored && active[1])
    begin
      fire = own | ({own[0], own[1]} & active & ~st.trigd);
    end
    for (int m = 0; m < 2; m++)
    begin
      // arm source is either the input edge or the other machine's trigger
      arm_ev[m] = running & active[m] & st.cfg.wait_arm[m] & ~st.armed[m]
        & (st.cfg.arm_from_other[m] ? st.trig_pulse[1-m] : ext_edge);
    end
    next_st.armed = st.armed | arm_ev;
    next_st.arm_pulse = arm_ev;
    next_st.trigd = st.trigd | fire;
    next_st.trig_pulse = fire;
    // source select only counts when the second machine is on
    if (running && st.cfg.out_en && !st.port_out
        && fire[st.cfg.m1_on ? st.cfg.out_src : 1'b0])
    begin
      next_st.port_out = 1'b1;
      ev[acarm_pkg::IRQ_PORT_OUT] = 1'b1;
    end
    // timing machines always tag; state machines tag by setting
    next_st.time_tag[0] = sample_i[0] & (st.cfg.timing[0] | st.cfg.tag0 == acarm_pkg::TAG_TIME);
    next_st.time_tag[1] = sample_i[1] & active[1]
      & (st.cfg.timing[1] | st.cfg.tag1 == acarm_pkg::TAG_TIME);
    next_st.state_cnt[0] = sample_i[0] & ~st.cfg.timing[0] & st.cfg.tag0 == acarm_pkg::TAG_STATE;
    next_st.state_cnt[1] = sample_i[1] & active[1] & ~st.cfg.timing[1]
      & st.cfg.tag1 == acarm_pkg::TAG_STATE;
    // state count tags never qualify two records for alignment
    corr_ok = st.cfg.m1_on & (st.cfg.timing[0] | st.cfg.tag0 == acarm_pkg::TAG_TIME)
      & (st.cfg.timing[1] | st.cfg.tag1 == acarm_pkg::TAG_TIME);
    // acquisition sequencing
    case (st.acq)
      acarm_pkg::ACQ_IDLE:
      begin
        next_st.acq = acarm_pkg::ACQ_IDLE;
      end
      acarm_pkg::ACQ_RUN:
      begin
        if ((next_st.trigd & active) == active)
        begin
          next_st.acq = acarm_pkg::ACQ_DONE;
        end
      end
      acarm_pkg::ACQ_DONE:
      begin
        next_st.acq = acarm_pkg::ACQ_DONE;
      end
      default:
      begin
        next_st.acq = acarm_pkg::ACQ_IDLE;
      end
    endcase
    // register writes
    if (wr_i)
    begin
      case (addr_i)
        acarm_pkg::ADDR_CTRL:
        begin
          next_st.cfg = wcfg;
          // a second timing machine is refused and flagged
          if (wcfg.timing == 2'h3)
          begin
            next_st.cfg.timing = 2'h1;
            ev[acarm_pkg::IRQ_CFG_ERR] = 1'b1;
          end
        end
        acarm_pkg::ADDR_CMD:
        begin
          if (wdata_i[acarm_pkg::CMD_START_BIT])
          begin
            next_st.acq = acarm_pkg::ACQ_RUN;
            next_st.armed = 2'h0;
            next_st.trigd = 2'h0;
            next_st.port_out = 1'b0;
          end
          else if (wdata_i[acarm_pkg::CMD_STOP_BIT])
          begin
            next_st.acq = acarm_pkg::ACQ_IDLE;
          end
        end
        acarm_pkg::ADDR_IRQ_STS:
        begin
          clr = wdata_i[acarm_pkg::IRQ_W-1:0];
        end
        acarm_pkg::ADDR_IRQ_MASK:
        begin
          next_st.mask = wdata_i[acarm_pkg::IRQ_W-1:0];
        end
        default:
        begin
          next_st.mask = st.mask;
        end
      endcase
    end
    // sticky events: a set in the clearing cycle survives
    ev[acarm_pkg::IRQ_EXT_ARM] = ext_edge;
    ev[acarm_pkg::IRQ_TRIG0] = fire[0];
    ev[acarm_pkg::IRQ_TRIG1] = fire[1];
    next_st.sts = (st.sts & ~clr) | ev;
    // register reads, answered in the next cycle
    if (rd_i)
    begin
      case (addr_i)
        acarm_pkg::ADDR_CTRL: next_st.rdata = 32'(st.cfg);
        acarm_pkg::ADDR_STATE: next_st.rdata = {23'h000000, corr_ok, st.port_out, st.trigd, st.armed, st.acq};
        acarm_pkg::ADDR_IRQ_STS: next_st.rdata = 32'(st.sts);
        acarm_pkg::ADDR_IRQ_MASK: next_st.rdata = 32'(st.mask);
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '{cfg: acarm_pkg::CFG_RESET, acq: acarm_pkg::ACQ_IDLE, sts: acarm_pkg::IRQ_RESET,
              mask: acarm_pkg::IRQ_RESET, rdata: 32'h00000000, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // enables are combinational so the sequencer sees them the same cycle
  always_comb
  begin
    for (int m = 0; m < 2; m++)
    begin
      mach_o[m].trig_en = en[m];
      mach_o[m].trig = st.trig_pulse[m];
      mach_o[m].arm_pulse = st.arm_pulse[m];
      mach_o[m].arm_level = m == 0 ? st.cfg.lvl0 : st.cfg.lvl1;
      mach_o[m].time_tag = st.time_tag[m];
      mach_o[m].state_cnt = st.state_cnt[m];
      mach_o[m].timing = st.cfg.timing[m];
    end
  end

  assign rdata_o = st.rdata;
  assign port_out_o = st.port_out;
  assign irq_o = |(st.sts & st.mask);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // second sync stage low, then high: one input edge
  sequence in_edge_s;
    !st.sync2 ##1 st.sync2;
  endsequence

  // machine 0 waits for an arm from the input pin
  sequence waiting0_s;
    running && st.cfg.wait_arm[0] && !st.cfg.arm_from_other[0] && !st.armed[0];
  endsequence

  // machine 1 waits for an arm from machine 0
  sequence chained1_s;
    running && st.cfg.m1_on && st.cfg.wait_arm[1] && st.cfg.arm_from_other[1] && !st.armed[1];
  endsequence

  // machine 1 sources the port but is still unarmed
  sequence src1_unarmed_s;
    st.cfg.m1_on && st.cfg.out_src && !st.cfg.ored && st.cfg.wait_arm[1] && !st.armed[1] && !st.port_out;
  endsequence

  // ****************************************
  // configuration and tag checks
  // ****************************************
  // the stored setting never holds two timing machines
  timing_excl_a: assert property (st.cfg.timing != 2'h3)
    else $error("both machines in timing mode");

  // a refused write is coerced and flagged in one step
  cfg_err_a: assert property (wr_i && addr_i == acarm_pkg::ADDR_CTRL && wdata_i[1:0] == 2'h3
    |=> st.cfg.timing == 2'h1 && st.sts[acarm_pkg::IRQ_CFG_ERR])
    else $error("double timing write not refused");

  // time tagging selected on a state machine
  tag_time_a: assert property (sample_i[0] && st.cfg.tag0 == acarm_pkg::TAG_TIME |=> mach_o[0].time_tag)
    else $error("time tag not stored");

  // counting off stores neither kind of tag
  tag_off_a: assert property (sample_i[0] && !st.cfg.timing[0] && st.cfg.tag0 == acarm_pkg::TAG_OFF
    |=> !mach_o[0].time_tag && !mach_o[0].state_cnt)
    else $error("tag stored with counting off");

  // state counting on machine 1 stores counts, not time
  tag_state_a: assert property (sample_i[1] && st.cfg.m1_on && !st.cfg.timing[1]
    && st.cfg.tag1 == acarm_pkg::TAG_STATE |=> mach_o[1].state_cnt && !mach_o[1].time_tag)
    else $error("state count tag not stored");

  // a timing machine tags whatever its setting says
  timing_tag_a: assert property (sample_i[1] && st.cfg.timing[1] && st.cfg.m1_on |=> mach_o[1].time_tag)
    else $error("timing machine lost time tag");

  // tagging the state machine alone suffices beside a timing one
  corr_timing_a: assert property (st.cfg.m1_on && st.cfg.timing[1] && st.cfg.tag0 == acarm_pkg::TAG_TIME
    |-> corr_ok)
    else $error("timing pair not correlated");

  // state counts never qualify a record for alignment
  corr_state_a: assert property (st.cfg.tag0 == acarm_pkg::TAG_STATE && !st.cfg.timing[0] |-> !corr_ok)
    else $error("state counts used for correlation");

  // ****************************************
  // trigger and port checks
  // ****************************************
  // a lone machine 0 raises the port and keeps it up
  port_rise_a: assert property (running && st.cfg.out_en && !st.port_out && !st.cfg.m1_on && fire[0]
    |=> port_out_o ##1 port_out_o)
    else $error("port out did not rise on trigger");

  // the port only falls on a new start
  port_hold_a: assert property (port_out_o
    && !(wr_i && addr_i == acarm_pkg::ADDR_CMD && wdata_i[acarm_pkg::CMD_START_BIT]) |=> port_out_o)
    else $error("port out fell during a run");

  // with machine 1 selected only its trigger raises the port
  src_sel_a: assert property (st.cfg.m1_on && st.cfg.out_src && !st.cfg.ored && $rose(port_out_o)
    |-> $past(fire[1]))
    else $error("port out from wrong machine");

  // combined mode: a hit on machine 0 forces machine 1
  ored_force_a: assert property (running && st.cfg.ored && st.cfg.m1_on && own[0] && !st.trigd[1]
    |=> mach_o[1].trig)
    else $error("other machine not forced");

  // combined mode: the first hit raises the port either way
  ored_port_a: assert property (running && !wr_i && st.cfg.ored && st.cfg.m1_on && st.cfg.out_en
    && !st.port_out && st.trigd == 2'h0 && own != 2'h0 |=> port_out_o)
    else $error("port out missing in combined mode");

  // an unarmed waiting machine never triggers on its own
  arm_gate_a: assert property (st.cfg.wait_arm[0] && !st.armed[0] && !st.cfg.ored |=> !mach_o[0].trig)
    else $error("trigger seen before arm");

  // ****************************************
  // arm delivery checks
  // ****************************************
  // an input edge arms a waiting machine 0 for one cycle
  edge_arm_a: assert property (in_edge_s ##0 waiting0_s
    |=> mach_o[0].arm_pulse ##1 !mach_o[0].arm_pulse)
    else $error("arm pulse missing or too long");

  // an arm pulse marks the cycle the machine became armed
  arm_deliver_a: assert property (mach_o[0].arm_pulse && !$past(wr_i)
    |-> st.armed[0] && !$past(st.armed[0]))
    else $error("arm pulse without a fresh arm");

  // machine 0's trigger arms a chained machine 1 for one cycle
  arm_other_a: assert property (chained1_s ##0 mach_o[0].trig
    |=> mach_o[1].arm_pulse ##1 !mach_o[1].arm_pulse)
    else $error("chained arm missing or too long");

  // an unarmed source keeps the port low
  src_wait_a: assert property (src1_unarmed_s |=> !port_out_o)
    else $error("port out before source was armed");

endmodule : acarm_core

//--- sim/acarm_instr.sv
`timescale 1ns/100ps
// ****************************************
// external instrument on the trigger lines
// ****************************************
module acarm_instr (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire logic port_out_i,
  output logic ext_trig_o,
  output logic [7:0] rises_o
);
  logic [2:0] hold;
  logic last_out;
  // arm is a rising edge held 4 cycles, then low long enough to resync
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold <= 3'h0;
      ext_trig_o <= 1'b0;
      last_out <= 1'b0;
      rises_o <= 8'h00;
    end
    else
    begin
      if (fire_i)
        hold <= 3'h4;
      else if (hold != 3'h0)
        hold <= hold - 3'h1;
      ext_trig_o <= fire_i || hold > 3'h1;
      last_out <= port_out_i;
      if (port_out_i && !last_out)
        rises_o <= rises_o + 8'h01; // only rising edges of port out are counted
    end
  end
endmodule : acarm_instr

//--- sim/acarm_core_tb_top.sv
`timescale 1ns/100ps
module acarm_core_tb_top;
  logic mclk_i, rst_n_i, wr_i, rd_i, fire, ext_trig, port_out_o, irq_o;
  logic [7:0] addr_i, rises;
  logic [31:0] wdata_i, rdata_o, v;
  logic [1:0] trig_hit_i, sample_i;
  acarm_pkg::acarm_mach_type [1:0] mach_o;
  int err_total, num_checks, cyc, n;
  acarm_core u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_hit_i(trig_hit_i), .sample_i(sample_i),
    .ext_trig_i(ext_trig), .mach_o(mach_o), .port_out_o(port_out_o), .irq_o(irq_o));
  acarm_instr u_instr (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fire_i(fire), .port_out_i(port_out_o),
    .ext_trig_o(ext_trig), .rises_o(rises));
  // ****************************************
  // clock, watchdog and bus tasks
  // ****************************************
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // a hang ends in the same verdict path
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      results();
    end
  end
  task results();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand one cycle only, so sample mid-cycle
  task rd(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    v = rdata_o;
  endtask : rd
  task cfg(input logic [31:0] c);
    wr(acarm_pkg::ADDR_CTRL, c);
    wr(acarm_pkg::ADDR_CMD, 32'h00000001);
  endtask : cfg
  task hit(input int m);
    @(posedge mclk_i);
    trig_hit_i[m] <= 1'b1;
    @(posedge mclk_i);
    trig_hit_i <= 2'h0;
    @(negedge mclk_i);
  endtask : hit
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    {rst_n_i, wr_i, rd_i, fire, addr_i, wdata_i, trig_hit_i, sample_i} = '0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(acarm_pkg::ADDR_CTRL);
    chk(v, 32'h0);
    chk(mach_o[0].arm_level, 32'h0);
    // double timing is refused and flagged
    wr(acarm_pkg::ADDR_CTRL, 32'h3);
    rd(acarm_pkg::ADDR_CTRL);
    chk(v, 32'h1);
    wr(acarm_pkg::ADDR_IRQ_MASK, 32'h10);
    @(negedge mclk_i);
    chk(irq_o, 1'b1);
    wr(acarm_pkg::ADDR_IRQ_STS, 32'h10);
    @(negedge mclk_i);
    chk(irq_o, 1'b0);
    // tag mode table: time, state, timing machine, off
    for (int i = 0; i < 4; i++)
    begin
      cfg(i == 0 ? 32'h4 : i == 1 ? 32'h8 : i == 2 ? 32'h1 : 32'h0);
      @(posedge mclk_i);
      sample_i <= 2'h1;
      @(posedge mclk_i);
      sample_i <= 2'h0;
      @(negedge mclk_i);
      chk(mach_o[0].time_tag, i[0] == 1'b0 && i != 3);
      chk(mach_o[0].state_cnt, i == 1);
      chk(mach_o[0].timing, i == 2);
    end
    cfg(32'h68);
    rd(acarm_pkg::ADDR_STATE);
    chk(v[8], 1'b0);
    cfg(32'h54);
    rd(acarm_pkg::ADDR_STATE);
    chk(v[8], 1'b1);
    // timing machine 1 beside a time-tagging machine 0
    cfg(32'h66);
    @(posedge mclk_i);
    sample_i <= 2'h2;
    @(posedge mclk_i);
    sample_i <= 2'h0;
    @(negedge mclk_i);
    chk({mach_o[1].timing, mach_o[1].time_tag, mach_o[1].state_cnt}, 3'h6);
    rd(acarm_pkg::ADDR_STATE);
    chk(v[8], 1'b1);
    // single machine drives the output port
    cfg(32'h80);
    hit(0);
    chk({mach_o[0].trig, port_out_o}, 2'h3);
    @(negedge mclk_i);
    chk(rises, 8'h01);
    rd(acarm_pkg::ADDR_STATE);
    chk(v & 32'h1E7, 32'hA4);
    rd(acarm_pkg::ADDR_IRQ_STS);
    chk(v & 32'hE, 32'hA);
    wr(acarm_pkg::ADDR_IRQ_MASK, 32'h8);
    @(negedge mclk_i);
    chk(irq_o, 1'b1);
    wr(acarm_pkg::ADDR_IRQ_STS, 32'h1F);
    @(negedge mclk_i);
    chk(irq_o, 1'b0);
    // source select on machine 1
    cfg(32'h1C0);
    hit(0);
    chk({mach_o[0].trig, port_out_o}, 2'h2);
    hit(1);
    chk({mach_o[1].trig, port_out_o}, 2'h3);
    // combined trigger fires both and the port
    cfg(32'h3C0);
    hit(0);
    chk({mach_o[0].trig, mach_o[1].trig, port_out_o}, 3'h7);
    // external arm to level 5 of machine 0
    cfg(32'h14400);
    @(negedge mclk_i);
    chk(mach_o[0].trig_en, 1'b0);
    hit(0);
    chk(mach_o[0].trig, 1'b0);
    @(posedge mclk_i);
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    n = 0;
    while (mach_o[0].arm_pulse !== 1'b1 && n < 8)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk(n, 32'h4);
    chk(mach_o[0].arm_level, 4'h5);
    @(negedge mclk_i);
    chk({mach_o[0].arm_pulse, mach_o[0].trig_en}, 2'h1);
    hit(0);
    chk(mach_o[0].trig, 1'b1);
    rd(acarm_pkg::ADDR_IRQ_STS);
    chk(v[0], 1'b1);
    // machine 1 waits for machine 0 and drives the port
    cfg(32'h29C0);
    hit(1);
    chk({mach_o[1].trig, port_out_o}, 2'h0);
    hit(0);
    chk(mach_o[0].trig, 1'b1);
    @(negedge mclk_i);
    chk({mach_o[1].arm_pulse, port_out_o}, 2'h2);
    hit(1);
    chk({mach_o[1].trig, port_out_o}, 2'h3);
    results();
  end
endmodule : acarm_core_tb_top
